// ### hw/fao_top.sv
// Fault alarm output: trip state to alarm outputs and relay
//
// Contract
// R1 - Alarm output active while fault uncleared
// R2 - Alarm inactive when no fault since clear
// R3 - Alarm assignable to either collector or relay
// R4 - Polarity 01: first closed normally, reversed tripped
// R5 - Polarity 00: relay sense inverted
// R6 - Normal means powered; trip or power-off flips (with polarity 00 power-off leaves the relay in its running position)
// R7 - Alarm follows trip mode entry and clear
// R8 - Alarm output registered on control clock
`timescale 1ns/100ps
`include "fao_map.svh"
module fao_top
  import fao_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  // Drive state (trip from the fault logic, power from a pin)
  input  wire logic     trip_i,
  input  wire logic     power_good_i,
  // Output configuration
  input  wire fao_cfg_s cfg_i,
  // Alarm signal and output drives
  output logic          fault_alarm_function_o,
  output fao_out_s      out_o
);

  ////////////////////////////////////////////////////////////////////////
  // Power-good arrives from a pin, so it is synchronised first
  logic power_ok; // Filtered power level
  fao_sync u_pwr_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (power_good_i),
    .level_o (power_ok)
  );

  ////////////////////////////////////////////////////////////////////////
  // All state in one struct
  typedef struct packed {
    logic     alarm; // Registered alarm signal
    fao_out_s outs;  // Registered output drives
  } fao_state_s;

  fao_state_s st;      // Current state
  fao_state_s next_st; // Next state

  ////////////////////////////////////////////////////////////////////////
  // Collector decode, one slice per open-collector output
  // Slice 1 is collector 11 and slice 0 is collector 12
  logic [15:0] oc_fn_bus;   // Both collector function codes
  logic [1:0]  oc_assigned; // Collector carries the alarm function

  // Pack the codes so both slices share one decode
  assign oc_fn_bus = {cfg_i.oc11_fn, cfg_i.oc12_fn};

  // R3 collector function select
  for (genvar g = 0; g < 2; g++) begin : g_oc
    // Any code but the alarm code leaves the collector off
    assign oc_assigned[g] = (oc_fn_bus[8*g +: 8] == `FAO_FUNC_ALARM);
  end

  ////////////////////////////////////////////////////////////////////////
  // Relay decode
  logic relay_assigned; // Relay carries the alarm function
  logic relay_inverted; // Contact sense inverted by polarity 00

  // R3 relay function select
  assign relay_assigned = (cfg_i.relay_fn == `FAO_FUNC_ALARM);
  // R5 polarity select; codes other than 00 keep the default sense
  assign relay_inverted = (cfg_i.polarity == `FAO_POL_INVERTED);

  ////////////////////////////////////////////////////////////////////////
  // Next state
  // Compute next alarm and output levels
  always_comb begin
    logic rel_trip;
    rel_trip = 1'b0;
    next_st  = st;
    // R1 active while uncleared
    // R2 inactive once cleared
    // R7 alarm from trip
    // Trip is same-clock logic; the fault logic clears it, not this block
    next_st.alarm = trip_i;
    // R3 collector drives
    next_st.outs.oc11_on = oc_assigned[1] & trip_i;
    next_st.outs.oc12_on = oc_assigned[0] & trip_i;
    // A relay without the alarm function keeps its normal position while power is good
    rel_trip = relay_assigned & trip_i;
    if (!power_ok) begin
      // R6 power loss position
      // An unpowered coil drops out, so polarity cannot apply here
      next_st.outs.relay_first_contact  = 1'b0;
      next_st.outs.relay_second_contact = 1'b1;
    end else if (relay_inverted) begin
      // R5 inverted contact sense
      next_st.outs.relay_first_contact  = rel_trip;
      next_st.outs.relay_second_contact = ~rel_trip;
    end else begin
      // R4 default contact sense
      next_st.outs.relay_first_contact  = ~rel_trip;
      next_st.outs.relay_second_contact = rel_trip;
    end
  end

  // R8 register on control clock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Unpowered view: first contact open, second closed
      st <= '{alarm: `FAO_ALARM_RESET,
              outs: '{oc11_on: `FAO_OC_RESET, oc12_on: `FAO_OC_RESET,
                      relay_first_contact: `FAO_FIRST_RESET,
                      relay_second_contact: `FAO_SECOND_RESET}};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign fault_alarm_function_o = st.alarm;
  assign out_o                  = st.outs;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Disabled in reset, where the outputs hold the unpowered view
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // R1 alarm while tripped
  a_alarm_follow_on: assert property ( // R1
    trip_i |=> fault_alarm_function_o)
    else $error("alarm not active after trip");

  // R2 alarm off when cleared
  a_alarm_clear_off: assert property ( // R2
    !trip_i |=> !fault_alarm_function_o)
    else $error("alarm active without trip");

  // R3 collector 11 follows
  a_oc11_assign: assert property ( // R3
    (cfg_i.oc11_fn == `FAO_FUNC_ALARM) |=>
      out_o.oc11_on == $past(trip_i))
    else $error("collector 11 not following alarm");

  // R3 collector 12 follows
  a_oc12_assign: assert property ( // R3
    (cfg_i.oc12_fn == `FAO_FUNC_ALARM) |=>
      out_o.oc12_on == $past(trip_i))
    else $error("collector 12 not following alarm");

  // R3 collector 11 idle
  a_oc11_unassigned: assert property ( // R3
    (cfg_i.oc11_fn != `FAO_FUNC_ALARM) |=> !out_o.oc11_on)
    else $error("collector 11 on without alarm function");

  // R3 collector 12 idle
  a_oc12_unassigned: assert property ( // R3
    (cfg_i.oc12_fn != `FAO_FUNC_ALARM) |=> !out_o.oc12_on)
    else $error("collector 12 on without alarm function");

  // R4 normal running position
  a_relay_normal_pol: assert property ( // R4
    (cfg_i.polarity == `FAO_POL_NORMAL && power_ok && !trip_i &&
     cfg_i.relay_fn == `FAO_FUNC_ALARM) |=>
      out_o.relay_first_contact && !out_o.relay_second_contact)
    else $error("relay wrong in normal polarity");

  // R4 trip reverses contacts
  a_relay_normal_trip: assert property ( // R4
    (cfg_i.polarity == `FAO_POL_NORMAL && power_ok && trip_i &&
     cfg_i.relay_fn == `FAO_FUNC_ALARM) |=>
      !out_o.relay_first_contact && out_o.relay_second_contact)
    else $error("relay wrong in normal polarity trip");

  // R5 inverted trip position
  a_relay_inv_trip: assert property ( // R5
    (cfg_i.polarity == `FAO_POL_INVERTED && power_ok && trip_i &&
     cfg_i.relay_fn == `FAO_FUNC_ALARM) |=>
      out_o.relay_first_contact && !out_o.relay_second_contact)
    else $error("relay wrong in inverted trip");

  // R5 inverted running position
  a_relay_inv_normal: assert property ( // R5
    (cfg_i.polarity == `FAO_POL_INVERTED && power_ok && !trip_i &&
     cfg_i.relay_fn == `FAO_FUNC_ALARM) |=>
      !out_o.relay_first_contact && out_o.relay_second_contact)
    else $error("relay wrong in inverted running");

  // R6 unassigned relay stays normal
  a_relay_unassigned: assert property ( // R6
    (cfg_i.polarity == `FAO_POL_NORMAL && power_ok &&
     cfg_i.relay_fn != `FAO_FUNC_ALARM) |=>
      out_o.relay_first_contact && !out_o.relay_second_contact)
    else $error("unassigned relay left normal position");

  // R6 power loss position
  a_relay_power_loss: assert property ( // R6
    !power_ok |=>
      !out_o.relay_first_contact && out_o.relay_second_contact)
    else $error("relay not flipped on power loss");

  // R4 contacts never agree
  a_contacts_exclusive: assert property ( // R4
    out_o.relay_first_contact != out_o.relay_second_contact)
    else $error("both contacts in same state");

  // R8 change one edge later
  a_alarm_edge_clock: assert property ( // R8
    $rose(trip_i) |-> !fault_alarm_function_o ##1 fault_alarm_function_o)
    else $error("alarm changed without clock edge");

  // Main scenarios: trip, clear, power loss, inverted trip, collector 12
  c_trip_seen:  cover property ($rose(fault_alarm_function_o));
  c_trip_clear: cover property ($fell(fault_alarm_function_o));
  c_power_loss: cover property ($fell(power_ok));
  c_inv_trip:   cover property (
    cfg_i.polarity == `FAO_POL_INVERTED && trip_i);
  c_oc12_alarm: cover property ($rose(out_o.oc12_on));
endmodule

// ### hw/fao_map.svh
// Constants of the fault alarm output block
`ifndef FAO_MAP_SVH
`define FAO_MAP_SVH
// Output function code that selects the alarm function
`define FAO_FUNC_ALARM     8'h05
// Contact polarity codes
`define FAO_POL_INVERTED   8'h00
`define FAO_POL_NORMAL     8'h01
// Polarity value after initialization
`define FAO_POL_RESET      8'h01
// Function code reset value for the relay (alarm)
`define FAO_RELAY_FN_RESET 8'h05
// Function code reset value for the open collectors (none)
`define FAO_OC_FN_RESET    8'h00
// Register reset values: the unpowered view of the outputs
`define FAO_ALARM_RESET    1'b0
`define FAO_OC_RESET       1'b0
`define FAO_FIRST_RESET    1'b0
`define FAO_SECOND_RESET   1'b1
`endif

// ### hw/fao_pkg.sv
// Types of the fault alarm output block
package fao_pkg;
  // Output function selectors for the three outputs
  typedef struct packed {
    logic [7:0] oc11_fn;
    logic [7:0] oc12_fn;
    logic [7:0] relay_fn;
    logic [7:0] polarity;
  } fao_cfg_s;
  // Drive levels of the three outputs
  typedef struct packed {
    logic oc11_on;
    logic oc12_on;
    logic relay_first_contact;
    logic relay_second_contact;
  } fao_out_s;
endpackage

// ### hw/fao_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module fao_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Asynchronous input and filtered level
  input  wire logic async_i,
  output logic      level_o
);
  // All state in one struct; the first stage is read only by the second
  typedef struct packed {
    logic [2:0] stage; // Shift stages, newest in bit 0
    logic       level; // Filtered level
  } fao_sync_s;

  fao_sync_s st;      // Current state
  fao_sync_s next_st; // Next state

  // Shift and take a change once stages two and three agree
  always_comb begin
    next_st       = st;
    next_st.stage = {st.stage[1:0], async_i};
    if (st.stage[1] == st.stage[2]) begin
      next_st.level = st.stage[2];
    end
  end

  // Reset to the low level, so power reads absent until seen
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Filtered level straight from its flip-flop
  assign level_o = st.level;
endmodule

// ### test/fao_load.sv
// Behavioural load wired to the relay and collector outputs
`timescale 1ns/100ps
module fao_load
  import fao_pkg::*;
(
  // Drives from the block
  input  wire fao_out_s   out_i,
  // What the far side sees
  output logic            load_on_o,
  output logic [1:0]      oc_level_o
);
  // Load fed through the common to first contact
  assign load_on_o  = out_i.relay_first_contact;
  // Pulled-up inputs read low while a transistor conducts
  assign oc_level_o = ~{out_i.oc11_on, out_i.oc12_on};
endmodule

// ### test/fao_top_bench.sv
// Self-checking bench for the fault alarm output block
`timescale 1ns/100ps
module fao_top_bench;
  import fao_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        trip_i = 1'b0;
  logic        power_good_i = 1'b1;
  fao_cfg_s    cfg_i = 32'h00000501;
  logic        alarm;
  fao_out_s    out;
  logic        load_on;
  logic [1:0]  oc_level;
  logic [15:0] lfsr = 16'h005f;
  fao_cfg_s    c;
  int          errors = 0;
  int          samples_checked = 0;
  ////////////////////////////////////////////////////////////////////
  always #25 clk_i = ~clk_i;
  fao_top u_fao_top (.clk_i(clk_i), .rst_i(rst_i), .trip_i(trip_i),
    .power_good_i(power_good_i), .cfg_i(cfg_i),
    .fault_alarm_function_o(alarm), .out_o(out));
  fao_load u_fao_load (.out_i(out), .load_on_o(load_on),
    .oc_level_o(oc_level));
  ////////////////////////////////////////////////////////////////////
  // Next value of the stimulus shift register
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected drives; power loss leaves the relay in its off position
  function automatic fao_out_s exp_out(logic t, logic p, fao_cfg_s f);
    logic r;
    r = t && (f.relay_fn === 8'h05);
    exp_out.oc11_on = t && (f.oc11_fn === 8'h05);
    exp_out.oc12_on = t && (f.oc12_fn === 8'h05);
    exp_out.relay_first_contact = p && (r ^ (f.polarity !== 8'h00));
    exp_out.relay_second_contact = !exp_out.relay_first_contact;
  endfunction
  task automatic check(string name, logic [3:0] seen, logic [3:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Power passes a synchroniser, so its changes get six edges
  task automatic apply(logic t, logic p, fao_cfg_s f, int waits);
    fao_out_s e;
    e = exp_out(t, p, f);
    @(posedge clk_i);
    trip_i <= t;
    power_good_i <= p;
    cfg_i <= f;
    repeat (waits) @(posedge clk_i);
    #1;
    check("alarm", {3'h0, alarm}, {3'h0, t});
    check("drives", out, e);
    check("load", {1'b0, load_on, oc_level},
      {1'b0, e.relay_first_contact, ~e.oc11_on, ~e.oc12_on});
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    errors++;
    complete_run();
  end
  initial begin
    repeat (7) @(posedge clk_i);
    #1;
    check("reset", out, 4'h1);
    @(posedge clk_i);
    rst_i <= 1'b0;
    // Corner cases: each polarity, power loss in trip, relay reassigned
    apply(1'b0, 1'b1, 32'h05050501, 6);
    apply(1'b1, 1'b1, 32'h05050501, 1);
    apply(1'b1, 1'b1, 32'h05000500, 1);
    apply(1'b0, 1'b1, 32'h00050500, 1);
    apply(1'b1, 1'b0, 32'h05050501, 6);
    apply(1'b0, 1'b0, 32'h05050500, 1);
    apply(1'b1, 1'b1, 32'h00050000, 6);
    for (int i = 0; i < 300; i++) begin
      lfsr = lfsr_next(lfsr);
      c.oc11_fn = lfsr[1] ? 8'h05 : lfsr[15:8];
      c.oc12_fn = lfsr[2] ? 8'h05 : lfsr[7:0];
      c.relay_fn = lfsr[3] ? 8'h05 : lfsr[11:4];
      c.polarity = lfsr[4] ? {7'h00, lfsr[5]} : lfsr[13:6];
      apply(lfsr[0], lfsr[15:13] != 3'h0, c,
        ((lfsr[15:13] != 3'h0) !== power_good_i) ? 6 : 1);
    end
    complete_run();
  end
endmodule
